// >>> hw/ppso_pkg.sv
// Constants and types for the port pin synchroniser and override block
package ppso_pkg;
  localparam int PPSO_NPINS = 8;
  localparam int PPSO_AW = 8;
  localparam logic [7:0] PPSO_OFF_DIR = 8'h00;
  localparam logic [7:0] PPSO_OFF_OUT = 8'h04;
  localparam logic [7:0] PPSO_OFF_PIN = 8'h08;
  localparam logic [7:0] PPSO_OFF_CTRL = 8'h0C;
  localparam int PPSO_CTRL_PUD_BIT = 0;
  localparam logic [7:0] PPSO_DIR_RST = 8'h00;
  localparam logic [7:0] PPSO_OUT_RST = 8'h00;
  localparam logic PPSO_PUD_RST = 1'b0;

  // Override bundle that one peripheral drives into one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } ppso_ovr_t;
endpackage

// >>> hw/ppso_port.sv
// One eight-pin port: APB registers, pad drive, input synchroniser, overrides
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ppso_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppso_pkg::PPSO_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppso_pkg::ppso_ovr_t [ppso_pkg::PPSO_NPINS-1:0] ovr,
  input wire logic sleep_input_clamp,
  input wire logic [ppso_pkg::PPSO_NPINS-1:0] ext_int_en,
  input wire logic [ppso_pkg::PPSO_NPINS-1:0] pad_in,
  output logic [ppso_pkg::PPSO_NPINS-1:0] pad_out,
  output logic [ppso_pkg::PPSO_NPINS-1:0] pad_oe_n,
  output logic [ppso_pkg::PPSO_NPINS-1:0] pullup_en,
  output logic [ppso_pkg::PPSO_NPINS-1:0] alt_digital_in,
  output logic [ppso_pkg::PPSO_NPINS-1:0] analog_pad_path
);
  localparam int N = ppso_pkg::PPSO_NPINS;

  logic [N-1:0] dir_q, dir_d, out_q, out_d;
  logic pud_q, pud_d;
  logic [N-1:0] latch_q, pin_q;
  logic [N-1:0] latch_d, pin_d;
  logic [N-1:0] schmitt, din_en;
  logic [N-1:0] pad_out_d, pad_oe_n_d, pullup_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic acc, wr, hit;

  function automatic logic ovr_sel(input logic en, input logic val, input logic norm);
    ovr_sel = en ? val : norm;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ppso_pkg::PPSO_OFF_DIR) || (a == ppso_pkg::PPSO_OFF_OUT) ||
                  (a == ppso_pkg::PPSO_OFF_PIN) || (a == ppso_pkg::PPSO_OFF_CTRL);
  endfunction

  // Input path: enable gate stands in front of the Schmitt trigger
  always_comb begin
    for (int i = 0; i < N; i++) begin
      din_en[i] = ovr_sel(ovr[i].input_en_override_en, ovr[i].input_en_override_val,
                          !(sleep_input_clamp && !ext_int_en[i]));
      // A clamped high pin rises on wake, which the edge logic sees as a change
      schmitt[i] = pad_in[i] && din_en[i];
    end
  end

  // Peripherals get the unsynchronised level and must sync it themselves
  assign alt_digital_in = schmitt;
  // Digital view of the pad for the analog path; no gating on it
  assign analog_pad_path = pad_in;

  // Only the sample stage reads the first stage, so a metastable first
  // stage gets half a period to settle before anything uses it
  always_comb begin
    latch_d = schmitt;
    pin_d = latch_q;
  end

  // Half-period first stage: captures on the falling edge like a latch
  // that closes when the clock goes low
  always_ff @(negedge clock) begin
    if (srst) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // Register bus decode; one wait state so pready comes from a flop
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign hit = addr_mapped(paddr);

  always_comb begin
    dir_d = dir_q;
    out_d = out_q;
    pud_d = pud_q;
    if (wr && paddr == ppso_pkg::PPSO_OFF_DIR) begin
      dir_d = pwdata[N-1:0];
    end
    if (wr && paddr == ppso_pkg::PPSO_OFF_OUT) begin
      out_d = pwdata[N-1:0];
    end
    if (wr && paddr == ppso_pkg::PPSO_OFF_PIN) begin
      out_d = out_q ^ pwdata[N-1:0];
    end
    if (wr && paddr == ppso_pkg::PPSO_OFF_CTRL) begin
      pud_d = pwdata[ppso_pkg::PPSO_CTRL_PUD_BIT];
    end
  end

  always_comb begin
    pready_d = psel && penable && !pready;
    pslverr_d = psel && penable && !pready && !hit;
    prdata_d = '0;
    if (psel && penable && !pready && !pwrite) begin
      case (paddr)
        ppso_pkg::PPSO_OFF_DIR: prdata_d[N-1:0] = dir_q;
        ppso_pkg::PPSO_OFF_OUT: prdata_d[N-1:0] = out_q;
        ppso_pkg::PPSO_OFF_PIN: prdata_d[N-1:0] = pin_q;
        ppso_pkg::PPSO_OFF_CTRL: prdata_d[ppso_pkg::PPSO_CTRL_PUD_BIT] = pud_q;
        default: prdata_d = '0;
      endcase
    end
  end

  // Pad controls use the next register values so a write reaches the pad
  // at its own edge and is sampled back one period later
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pad_oe_n_d[i] = !ovr_sel(ovr[i].dir_override_en, ovr[i].dir_override_val,
                               dir_d[i]);
      pad_out_d[i] = ovr_sel(ovr[i].value_override_en, ovr[i].value_override_val,
                             out_d[i] ^ ovr[i].toggle_override_en);
      pullup_d[i] = ovr_sel(ovr[i].pullup_override_en, ovr[i].pullup_override_val,
                            !dir_d[i] && out_d[i] && !pud_d);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dir_q <= ppso_pkg::PPSO_DIR_RST;
      out_q <= ppso_pkg::PPSO_OUT_RST;
      pud_q <= ppso_pkg::PPSO_PUD_RST;
      pad_oe_n <= '1;
      pad_out <= '0;
      pullup_en <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
      pud_q <= pud_d;
      pad_oe_n <= pad_oe_n_d;
      pad_out <= pad_out_d;
      pullup_en <= pullup_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  a_sample_two_stage: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) |-> pin_q == $past(latch_q))
    else $error("sample bit did not load the latch value");

  a_pullup_select: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) |->
      pullup_en[0] == ($past(ovr[0].pullup_override_en) ? $past(ovr[0].pullup_override_val)
                       : (!dir_q[0] && out_q[0] && !pud_q)))
    else $error("pull-up does not match its controls");

  a_driver_enable: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) |->
      pad_oe_n[0] == !($past(ovr[0].dir_override_en) ? $past(ovr[0].dir_override_val)
                       : dir_q[0]))
    else $error("driver enable does not match direction");

  a_driven_level: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) && !pad_oe_n[0] |->
      pad_out[0] == ($past(ovr[0].value_override_en) ? $past(ovr[0].value_override_val)
                     : out_q[0] ^ $past(ovr[0].toggle_override_en)))
    else $error("driven level wrong");

  a_pin_toggle: assert property (
    @(posedge clock) disable iff (srst)
      wr && paddr == ppso_pkg::PPSO_OFF_PIN && pwdata[0] |=> out_q[0] != $past(out_q[0]))
    else $error("toggle write did not invert latch");

  a_sleep_clamp: assert property (
    @(posedge clock) disable iff (srst)
      sleep_input_clamp && !ext_int_en[0] && !ovr[0].input_en_override_en |->
      alt_digital_in[0] == 1'b0)
    else $error("clamped input not grounded");

  a_clamp_exempt: assert property (
    @(posedge clock) disable iff (srst)
      ext_int_en[0] && !ovr[0].input_en_override_en |-> alt_digital_in[0] == pad_in[0])
    else $error("interrupt pin was clamped");

  a_reset_tristate: assert property (
    @(posedge clock) $past(srst) |-> pad_oe_n == '1 && pullup_en == '0)
    else $error("pins not tri-stated after reset");

  a_apb_answer: assert property (
    @(posedge clock) disable iff (srst) psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

  // A level that has stood over two rising edges must be in the sample bit
  a_sample_delay: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) && $stable(schmitt[0]) &&
      $past($stable(schmitt[0])) |-> pin_q[0] == schmitt[0])
    else $error("sample bit slower than allowed");

  a_write_to_pad: assert property (
    @(posedge clock) disable iff (srst) wr && paddr == ppso_pkg::PPSO_OFF_OUT &&
      !ovr[0].value_override_en && !ovr[0].toggle_override_en |=> pad_out[0] == $past(pwdata[0]))
    else $error("written value not at pad on its edge");

  a_dir_write: assert property (
    @(posedge clock) disable iff (srst)
      wr && paddr == ppso_pkg::PPSO_OFF_DIR |=> dir_q == $past(pwdata[N-1:0]))
    else $error("direction write lost");

  a_out_write: assert property (
    @(posedge clock) disable iff (srst)
      wr && paddr == ppso_pkg::PPSO_OFF_OUT |=> out_q == $past(pwdata[N-1:0]))
    else $error("output latch write lost");

  a_pin_zero_keep: assert property (
    @(posedge clock) disable iff (srst)
      wr && paddr == ppso_pkg::PPSO_OFF_PIN && !pwdata[0] |=> out_q[0] == $past(out_q[0]))
    else $error("zero write to sample bit changed latch");

  a_dir_hold: assert property (
    @(posedge clock) disable iff (srst) !wr |=> dir_q == $past(dir_q) && out_q == $past(out_q))
    else $error("registers changed without a write");

  a_pud_kill: assert property (
    @(posedge clock) disable iff (srst)
      !$past(srst) && pud_q && !$past(ovr[0].pullup_override_en) |-> !pullup_en[0])
    else $error("pull-up on while globally off");

  a_pullup_ovr: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) && $past(ovr[1].pullup_override_en) |->
      pullup_en[1] == $past(ovr[1].pullup_override_val))
    else $error("pull-up override ignored");

  a_toggle_ovr: assert property (
    @(posedge clock) disable iff (srst) !$past(srst) && $past(ovr[1].toggle_override_en) &&
      !$past(ovr[1].value_override_en) |-> pad_out[1] == !out_q[1])
    else $error("toggle override did not invert");

  a_dir_default: assert property (
    @(posedge clock) disable iff (srst)
      !$past(srst) && !$past(ovr[2].dir_override_en) |-> pad_oe_n[2] == !dir_q[2])
    else $error("driver enable not from direction bit");

  a_input_ovr: assert property (
    @(posedge clock) disable iff (srst) ovr[5].input_en_override_en |->
      alt_digital_in[5] == (pad_in[5] && ovr[5].input_en_override_val))
    else $error("input enable override ignored");

  a_awake_input: assert property (
    @(posedge clock) disable iff (srst) !sleep_input_clamp && !ovr[0].input_en_override_en |->
      alt_digital_in[0] == pad_in[0])
    else $error("input gated while awake");

  a_analog_pass: assert property (
    @(posedge clock) disable iff (srst) analog_pad_path == pad_in)
    else $error("analog path not the pad");

  a_unmapped_err: assert property (
    @(posedge clock) disable iff (srst) psel && penable && !pready && !hit |=> pslverr)
    else $error("unmapped access without error");

  a_mapped_ok: assert property (
    @(posedge clock) disable iff (srst) psel && penable && !pready && hit |=> !pslverr)
    else $error("error on mapped access");

  a_unmapped_zero: assert property (
    @(posedge clock) disable iff (srst)
      psel && penable && !pready && !hit && !pwrite |=> prdata == '0)
    else $error("unmapped read not zero");

  a_read_dir: assert property (
    @(posedge clock) disable iff (srst) psel && penable && !pready && !pwrite &&
      paddr == ppso_pkg::PPSO_OFF_DIR |=> prdata[N-1:0] == $past(dir_q))
    else $error("direction read wrong");

  a_read_pin: assert property (
    @(posedge clock) disable iff (srst) psel && penable && !pready && !pwrite &&
      paddr == ppso_pkg::PPSO_OFF_PIN |=> prdata[N-1:0] == $past(pin_q))
    else $error("sample read wrong");

  a_reset_regs: assert property (
    @(posedge clock) $past(srst) |-> dir_q == '0 && out_q == '0 && pin_q == '0 && !pready)
    else $error("state not cleared by reset");
endmodule

// >>> dv/ppso_pad_model.sv
// Pad model: driven level loops back, otherwise the external source shows
`timescale 1ns/1ps
module ppso_pad_model (
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] ext_lvl,
  output logic [7:0] pad_in
);
  // Strong driver wins, so an undriven pin never keeps a stale level
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_lvl);
endmodule

// >>> dv/test_port_pin_sync_and_override.sv
// Self-checking bench for the port pin synchroniser and override block
`timescale 1ns/1ps
module test_port_pin_sync_and_override;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
  logic [7:0] paddr = 0, ext_int_en = 0, ext = 0, pad_in, pad_out, pad_oe_n;
  logic [7:0] pullup_en, alt_digital_in, analog_pad_path;
  logic [31:0] pwdata = 0, prdata, rd;
  logic clamp = 0, err;
  ppso_pkg::ppso_ovr_t [7:0] ovr = '0;
  int n_errors = 0, tests_run = 0;
  always #2.5 clock = ~clock;
  ppso_port i_ppso_port (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ovr(ovr), .sleep_input_clamp(clamp), .ext_int_en(ext_int_en),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
    .alt_digital_in(alt_digital_in), .analog_pad_path(analog_pad_path));
  ppso_pad_model i_ppso_pad_model (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .ext_lvl(ext), .pad_in(pad_in));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until pready is seen high at the taking edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  task t_reset;
    chk("oe_n", 8'hFF, pad_oe_n);
    chk("pullup", 8'h00, pullup_en);
    apb(0, ppso_pkg::PPSO_OFF_DIR, 0); chk("dir", 0, rd);
  endtask
  task t_io;
    ext <= 8'h30;
    apb(1, ppso_pkg::PPSO_OFF_OUT, 32'h5A); settle; chk("pu", 8'h5A, pullup_en);
    apb(1, ppso_pkg::PPSO_OFF_DIR, 32'h0F); settle; chk("oe_n", 8'hF0, pad_oe_n);
    chk("out", 8'h0A, pad_out & 8'h0F);
    @(posedge clock);
    apb(0, ppso_pkg::PPSO_OFF_PIN, 0); chk("pin", 32'h3A, rd);
    apb(1, ppso_pkg::PPSO_OFF_CTRL, 1); settle; chk("pud", 8'h00, pullup_en);
    apb(1, ppso_pkg::PPSO_OFF_CTRL, 0);
    apb(1, ppso_pkg::PPSO_OFF_PIN, 32'h03); apb(0, ppso_pkg::PPSO_OFF_OUT, 0);
    chk("toggle", 32'h59, rd);
    apb(0, 8'h10, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
  endtask
  task t_ovr;
    ppso_pkg::ppso_ovr_t [7:0] o;
    o = '0;
    o[0].pullup_override_en = 1;
    o[0].pullup_override_val = 1;
    o[4].dir_override_en = 1;
    o[4].dir_override_val = 1;
    o[4].value_override_en = 1;
    o[4].value_override_val = 1;
    o[1].toggle_override_en = 1;
    ovr <= o;
    settle;
    chk("pu ovr", 1, pullup_en[0]);
    chk("oe_n ovr", 8'hE0, pad_oe_n);
    chk("out ovr", 8'h1B, pad_out & 8'h1F);
  endtask
  task t_sleep;
    ppso_pkg::ppso_ovr_t [7:0] o;
    o = '0;
    o[5].input_en_override_en = 1;
    o[5].input_en_override_val = 1;
    ovr <= o; ext <= 8'hF0; ext_int_en <= 8'h10; clamp <= 1;
    settle;
    chk("clamped", 8'h30, alt_digital_in);
    chk("analog", 8'hF9, analog_pad_path);
    clamp <= 0; settle; chk("awake", 8'hF9, alt_digital_in);
  endtask
  task summarize;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #5000;
    n_errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clock);
    srst <= 0;
    @(posedge clock);
    t_reset; t_io; t_ovr; t_sleep;
    summarize;
  end
endmodule
